// *** hdl/serial_sar_adc_readout.sv ***
// Frame sequencing, track/hold control and serial result shifting
`timescale 1ns/1ns
`default_nettype none
module serial_sar_adc_readout
    import sar_readout_pkg::*;
#(
    parameter bit TEN_BIT_VARIANT = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        frame_select_n,
    input  wire logic        serial_clock,
    input  wire logic [11:0] conversion_code,
    output logic             serial_result_out,
    output logic             serial_result_oe,
    output logic             track_hold,
    output logic             sample_strobe,
    output logic             conversion_busy
);
    logic         select_sync_n;
    logic         sclk_sync;
    logic         select_prev_n;
    logic         sclk_prev;
    frame_state_t state;
    frame_state_t next_state;
    logic [4:0]   fall_count;
    logic [4:0]   next_fall_count;
    logic [15:0]  shift;
    logic [15:0]  next_shift;
    logic         track_pending;
    logic         next_track_pending;
    logic         next_track_hold;
    logic         next_oe;
    logic         next_data;

    // Pins come from outside this clock, so both are synchronised first
    sync_two_ff #(.RESET_VALUE(1'b1)) u_sync_select (
        .clk      (clk),
        .reset    (reset),
        .async_in (frame_select_n),
        .sync_out (select_sync_n)
    );
    sync_two_ff #(.RESET_VALUE(1'b0)) u_sync_sclk (
        .clk      (clk),
        .reset    (reset),
        .async_in (serial_clock),
        .sync_out (sclk_sync)
    );

    wire select_fall = select_prev_n & ~select_sync_n;
    wire select_rise = ~select_prev_n & select_sync_n;
    wire sclk_fall   = sclk_prev & ~sclk_sync;
    wire sclk_rise   = ~sclk_prev & sclk_sync;
    wire in_frame    = (state == ST_CONVERT);
    // Straight binary code, no transform; the analog side scales it
    wire [15:0] frame_word_12 = {LEAD_ZERO_BITS, conversion_code};
    wire [15:0] frame_word_10 = {LEAD_ZERO_BITS, conversion_code[11:2], TRAIL_ZEROS_10};
    wire [15:0] frame_word    = TEN_BIT_VARIANT ? frame_word_10 : frame_word_12;
    wire        counted_fall  = in_frame & sclk_fall & ~select_sync_n;
    wire [4:0]  fall_plus_one = fall_count + 5'h01;

    always_comb
    begin
        next_state         = state;
        next_fall_count    = fall_count;
        next_shift         = shift;
        next_track_pending = track_pending;
        next_track_hold    = track_hold;
        next_oe            = serial_result_oe;
        next_data          = serial_result_out;
        case (state)
            ST_IDLE, ST_DONE:
            begin
                if (select_fall)
                begin
                    // Hold, drive the pin with the first leading zero
                    next_state         = ST_CONVERT;
                    next_fall_count    = FALL_COUNT_RST;
                    next_shift         = {frame_word[14:0], 1'b0};
                    next_track_hold    = 1'b0;
                    next_track_pending = 1'b0;
                    next_oe            = 1'b1;
                    next_data          = frame_word[15];
                end
                else if (select_rise)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_CONVERT:
            begin
                if (select_rise)
                begin
                    // Early end abandons everything and releases the line
                    next_state         = ST_IDLE;
                    next_oe            = 1'b0;
                    next_track_hold    = 1'b1;
                    next_track_pending = 1'b0;
                end
                else
                begin
                    if (counted_fall)
                    begin
                        next_fall_count = fall_plus_one;
                        if (fall_plus_one == LAST_FALLS)
                        begin
                            // Frame complete; host holds the last bit now
                            next_oe    = 1'b0;
                            next_state = ST_DONE;
                        end
                        else
                        begin
                            next_data  = shift[15];
                            next_shift = {shift[14:0], 1'b0};
                        end
                        if (fall_plus_one == TRACK_FALLS)
                        begin
                            next_track_pending = 1'b1;
                        end
                    end
                    if (sclk_rise && track_pending)
                    begin
                        next_track_hold    = 1'b1;
                        next_track_pending = 1'b0;
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            select_prev_n <= 1'b1;
            sclk_prev     <= 1'b0;
            state         <= ST_IDLE;
        end
        else
        begin
            select_prev_n <= select_sync_n;
            sclk_prev     <= sclk_sync;
            state         <= next_state;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            fall_count    <= FALL_COUNT_RST;
            shift         <= SHIFT_RST;
            track_pending <= 1'b0;
        end
        else
        begin
            fall_count    <= next_fall_count;
            shift         <= next_shift;
            track_pending <= next_track_pending;
        end
    end

    // Outputs except conversion_busy straight from flip-flops so the pin never glitches
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            track_hold        <= 1'b1;
            serial_result_oe  <= 1'b0;
            serial_result_out <= 1'b0;
            sample_strobe     <= 1'b0;
        end
        else
        begin
            track_hold        <= next_track_hold;
            serial_result_oe  <= next_oe;
            serial_result_out <= next_data;
            sample_strobe     <= select_fall & (state != ST_CONVERT);
        end
    end

    assign conversion_busy = in_frame;

    sequence start_seq;
        select_fall && (state != ST_CONVERT);
    endsequence

    start_drives_a: assert property (@(posedge clk) disable iff (reset)
        start_seq |=> (serial_result_oe && !track_hold && !serial_result_out))
        else $error("select fall did not hold and drive");
    start_samples_a: assert property (@(posedge clk) disable iff (reset)
        start_seq |=> (sample_strobe && conversion_busy))
        else $error("select fall did not start conversion");
    early_release_a: assert property (@(posedge clk) disable iff (reset)
        (in_frame && select_rise) |=> (!serial_result_oe && state == ST_IDLE))
        else $error("early select rise did not release line");
    last_fall_a: assert property (@(posedge clk) disable iff (reset)
        (counted_fall && !select_rise && fall_count == 5'h0F) |=> (!serial_result_oe && state == ST_DONE))
        else $error("line not released at 16th fall");
    track_return_a: assert property (@(posedge clk) disable iff (reset)
        (in_frame && !select_rise && sclk_rise && track_pending) |=> track_hold)
        else $error("track not resumed after 13th fall");
    no_early_track_a: assert property (@(posedge clk) disable iff (reset)
        (in_frame && fall_count < TRACK_FALLS) |-> !track_hold)
        else $error("track resumed too early");
    idle_released_a: assert property (@(posedge clk) disable iff (reset)
        (state != ST_CONVERT) && !select_fall |=> !serial_result_oe)
        else $error("line driven outside frame");
    shift_on_fall_a: assert property (@(posedge clk) disable iff (reset)
        (counted_fall && !select_rise && fall_count < 5'h0F) |=> (serial_result_out == $past(shift[15])))
        else $error("bit not shifted on fall");
    lead_zeros_a: assert property (@(posedge clk) disable iff (reset)
        (in_frame && serial_result_oe && fall_count < 5'h04) |-> !serial_result_out)
        else $error("leading zero missing");
endmodule
`default_nettype wire

// *** hdl/sar_readout_pkg.sv ***
// Constants for the serial converter readout block
package sar_readout_pkg;
    localparam int unsigned FRAME_BITS      = 16;
    localparam int unsigned LEAD_ZEROS      = 4;
    localparam int unsigned TRACK_AFTER_FALLS = 13;
    localparam int unsigned RES_BITS_12     = 12;
    localparam int unsigned RES_BITS_10     = 10;
    localparam logic [4:0]  FALL_COUNT_RST  = 5'h00;
    localparam logic [4:0]  TRACK_FALLS     = 5'h0D;
    localparam logic [4:0]  LAST_FALLS      = 5'h10;
    localparam logic [15:0] SHIFT_RST       = 16'h0000;
    localparam logic [11:0] FULL_SCALE_12   = 12'hFFF;
    localparam logic [9:0]  FULL_SCALE_10   = 10'h3FF;
    localparam logic [1:0]  TRAIL_ZEROS_10  = 2'h0;
    localparam logic [3:0]  LEAD_ZERO_BITS  = 4'h0;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_DONE
    } frame_state_t;
endpackage

// *** hdl/sync_two_ff.sv ***
// Two flip-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage_one;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stage_one <= RESET_VALUE;
            sync_out  <= RESET_VALUE;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule
`default_nettype wire

// *** test/serial_host_model.sv ***
// Host serial port model: drives select and serial clock, captures the data lines
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
    input  wire logic line_a,
    input  wire logic line_b,
    input  wire logic track_in,
    output logic      frame_select_n,
    output logic      serial_clock
);
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic [15:0] hold_seen;
    initial
    begin
        frame_select_n = 1'b1;
        serial_clock   = 1'b0;
    end
    // Frame of n serial clocks, 40 ns halves; a whole result needs 16
    task automatic frame(input int n);
        frame_select_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++)
        begin
            serial_clock = 1'b1;
            #40;
            if (i < 16)
            begin
                word_a[15-i]    = line_a;
                word_b[15-i]    = line_b;
                hold_seen[15-i] = track_in;
            end
            serial_clock = 1'b0;
            #40;
        end
        #70;
    endtask
    // Select stays high long enough for acquisition and quiet time
    task automatic release_frame;
        frame_select_n = 1'b1;
        #300;
    endtask
    // Serial clock activity with no frame open
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            serial_clock = 1'b1;
            #40;
            serial_clock = 1'b0;
            #40;
        end
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the serial converter readout
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sar_readout_pkg::*;
    logic        clk;
    logic        reset;
    logic        frame_select_n;
    logic        serial_clock;
    logic [11:0] code;
    logic        out_a;
    logic        oe_a;
    logic        th_a;
    logic        strobe_a;
    logic        busy_a;
    logic        out_b;
    logic        oe_b;
    logic        last_a = 1'b0;
    logic        last_b = 1'b0;
    logic        line_a;
    logic        line_b;
    int          error_cnt;
    int          n_compared;
    int          strobe_cnt = 0;
    // Released pin shows the inverse of its last value, no pull on the line
    assign line_a = oe_a ? out_a : ~last_a;
    assign line_b = oe_b ? out_b : ~last_b;
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        if (oe_a) last_a <= out_a;
        if (oe_b) last_b <= out_b;
        if (strobe_a === 1'b1) strobe_cnt <= strobe_cnt + 1;
    end
    serial_sar_adc_readout i_serial_sar_adc_readout (.clk(clk), .reset(reset),
        .frame_select_n(frame_select_n), .serial_clock(serial_clock), .conversion_code(code),
        .serial_result_out(out_a), .serial_result_oe(oe_a), .track_hold(th_a),
        .sample_strobe(strobe_a), .conversion_busy(busy_a));
    serial_sar_adc_readout #(.TEN_BIT_VARIANT(1'b1)) i_serial_sar_adc_readout_ten (.clk(clk),
        .reset(reset), .frame_select_n(frame_select_n), .serial_clock(serial_clock),
        .conversion_code(code), .serial_result_out(out_b), .serial_result_oe(oe_b),
        .track_hold(), .sample_strobe(), .conversion_busy());
    serial_host_model i_serial_host_model (.line_a(line_a), .line_b(line_b), .track_in(th_a),
        .frame_select_n(frame_select_n), .serial_clock(serial_clock));
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("error_cnt %0d n_compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Full frame, or one with extra clocks that must be ignored
    task automatic run_full(input logic [11:0] c, input int n);
        int s0;
        s0 = strobe_cnt;
        code = c;
        i_serial_host_model.frame(n);
        chk16(i_serial_host_model.word_a, {LEAD_ZERO_BITS, c}, "frame12");
        chk16(i_serial_host_model.word_b, {LEAD_ZERO_BITS, c[11:2], TRAIL_ZEROS_10}, "frame10");
        chk16(i_serial_host_model.hold_seen, 16'h0007, "track");
        chk1(oe_a, 1'b0, "release12");
        chk1(oe_b, 1'b0, "release10");
        chk1(busy_a, 1'b0, "busy");
        chk16(16'(strobe_cnt - s0), 16'h0001, "strobe");
        i_serial_host_model.release_frame();
    endtask
    task automatic run_abort;
        i_serial_host_model.frame(5);
        chk1(oe_a, 1'b1, "drive mid");
        chk1(th_a, 1'b0, "hold mid");
        chk1(busy_a, 1'b1, "busy mid");
        i_serial_host_model.release_frame();
        chk1(oe_a, 1'b0, "abort release");
        chk1(th_a, 1'b1, "abort track");
        chk1(busy_a, 1'b0, "abort busy");
    endtask
    // Serial clock with select high must change nothing
    task automatic run_idle;
        int s0;
        s0 = strobe_cnt;
        i_serial_host_model.idle_clocks(20);
        chk1(oe_a, 1'b0, "idle oe");
        chk16(16'(strobe_cnt - s0), 16'h0000, "idle strobe");
    endtask
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        code = 12'h000;
        error_cnt = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        run_idle();
        run_full(12'h000, 16);
        run_full(FULL_SCALE_12, 16);
        run_full(12'hA5C, 16);
        run_abort();
        run_full(12'h801, 18);
        run_full(12'h3C7, 16);
        run_idle();
        end_sim();
    end
    // A hang counts as a mismatch
    initial
    begin
        #200000;
        error_cnt++;
        $display("BAD %0t timeout", $time);
        end_sim();
    end
endmodule
`default_nettype wire
